// file: hdl/rstx_regs.svh
// Constants for the regenerator section frame source and its payload source.
`ifndef RSTX_REGS_SVH
`define RSTX_REGS_SVH
`define RSTX_ROWS          9
`define RSTX_COLS          270
`define RSTX_SOH_COLS      9
`define RSTX_FRAME_BYTES   2430
`define RSTX_PAYLOAD_BYTES 2403
`define RSTX_FRAME_US      125
`define RSTX_CLK_MHZ       10
`define RSTX_FRAME_CYCLES  (`RSTX_FRAME_US * `RSTX_CLK_MHZ)
`define RSTX_FAW1          8'hF6
`define RSTX_FAW2          8'h28
`define RSTX_SCR_SEED      7'h7F
`define RSTX_COL_TRACE     7
`define RSTX_COL_NU1       8
`define RSTX_COL_NU2       9
`define RSTX_COL_PARITY    1
`define RSTX_COL_ORDERWIRE 4
`define RSTX_COL_USER      7
`define RSTX_ROW_MGMT      3
`endif

// file: hdl/rstx_pkg.sv
// Types shared by both ends of the section frame link.
package rstx_pkg;
   typedef logic [7:0] rstx_byte_t;
   typedef enum logic [1:0] {
      RSTX_FAW   = 2'b00,
      RSTX_UNSCR = 2'b01,
      RSTX_PAR   = 2'b11,
      RSTX_SCR   = 2'b10
   } rstx_kind_t;
endpackage

// file: hdl/rstx_link_if.sv
// Interface between the payload source and the section frame source.
`timescale 1ns/1ps
interface rstx_link_if;
   import rstx_pkg::*;
   logic       fs;
   rstx_byte_t ai_data;
   logic       mgmt_en;
   logic       ow_en;
   logic       usr_en;
   modport source (input fs, output ai_data, output mgmt_en, output ow_en, output usr_en);
   modport term (output fs, input ai_data, input mgmt_en, input ow_en, input usr_en);
endinterface

// file: hdl/rstx_payload_src.sv
// Payload source end: fills the adapted payload byte for each frame slot.
`timescale 1ns/1ps
`include "rstx_regs.svh"
module rstx_payload_src (
   // System
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Link
   rstx_link_if.source            link,
   // User side
   input  wire rstx_pkg::rstx_byte_t ms_data,
   output logic                   ms_take,
   input  wire rstx_pkg::rstx_byte_t mgmt_data,
   input  wire logic              mgmt_valid,
   input  wire rstx_pkg::rstx_byte_t ow_data,
   input  wire logic              ow_valid,
   input  wire rstx_pkg::rstx_byte_t usr_data,
   input  wire logic              usr_valid,
   input  wire rstx_pkg::rstx_byte_t nu_data
);
   import rstx_pkg::*;
   logic [8:0]  col_reg, col_next;
   logic [3:0]  row_reg, row_next;
   rstx_byte_t  data_reg, data_next;
   logic        section_overhead;

   // Slot position is counted from the frame start that the terminator sends.
   always_comb begin
      col_next = col_reg + 9'h001;
      row_next = row_reg;
      // The pulse stands on the cycle that reads slot zero, so the next slot is the second.
      if (link.fs) begin
         col_next = 9'h001;
         row_next = 4'h0;
      end else if (col_reg == 9'(`RSTX_COLS - 1)) begin
         col_next = 9'h000;
         row_next = (row_reg == 4'(`RSTX_ROWS - 1)) ? 4'h0 : row_reg + 4'h1;
      end
   end

   assign section_overhead = (col_next < 9'(`RSTX_SOH_COLS)) && (row_next < 4'h3);

   // The byte is prepared for the slot the terminator reads on the next edge.
   always_comb begin
      ms_take   = 1'b0;
      data_next = 8'h00;
      if (!section_overhead) begin
         data_next = ms_data; // R2
         ms_take   = 1'b1;
      end else if (row_next == 4'(`RSTX_ROW_MGMT - 1) && col_next % 9'h003 == 9'h000) begin
         data_next = mgmt_data; // R3
      end else if (row_next == 4'h1 && col_next == 9'(`RSTX_COL_ORDERWIRE - 1)) begin
         data_next = ow_data; // R4
      end else if (row_next == 4'h1 && col_next == 9'(`RSTX_COL_USER - 1)) begin
         data_next = usr_data; // R5
      end else if (row_next == 4'h0 && col_next >= 9'(`RSTX_COL_NU1 - 1)) begin
         data_next = nu_data; // R18
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         col_reg  <= 9'h000;
         row_reg  <= 4'h0;
         data_reg <= 8'h00;
      end else begin
         col_reg  <= col_next;
         row_reg  <= row_next;
         data_reg <= data_next;
      end
   end

   assign link.ai_data = data_reg;
   assign link.mgmt_en = mgmt_valid;
   assign link.ow_en   = ow_valid;
   assign link.usr_en  = usr_valid;
endmodule // rstx_payload_src

// file: hdl/rstx_section_term.sv
// Section frame source: framing, trace, parity and scrambling of the line signal.
`timescale 1ns/1ps
`include "rstx_regs.svh"
// Overview of operation
// R1: Byte stream framed every 125 microseconds; the code frames every 2430 clocks, 243 microseconds at 10 MHz.
// R2: Payload carries 2403 multiplex section bytes.
// R3: Management channel uses three overhead bytes.
// R4: Orderwire uses one overhead byte.
// R5: User channel uses one overhead byte.
// R6: Unsourced channel bytes may stay undefined.
// R7: Add framing, trace and parity bytes.
// R8: Trace byte carries configured trace identifier.
// R9: Parity is even bit-interleaved BIP-8.
// R10: Parity covers whole previous scrambled frame.
// R11: Previous parity inserted before scrambling.
// R12: Insert three first then three second framing.
// R13: Frame-synchronous scrambler, length 127, bit-serial.
// R14: Polynomial one plus x6 plus x7.
// R15: Scrambler all ones at row1 column10.
// R16: Each bit xored with stage seven.
// R17: Scrambler runs through rest of frame.
// R18: Unused national bytes avoid long runs.
// R19: First-row overhead bytes stay unscrambled.
// R20: No defects, actions or counts kept.
module rstx_section_term #(
   parameter int FRAME_BYTES = `RSTX_FRAME_BYTES
) (
   // System
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // Link to payload source
   rstx_link_if.term                 link,
   // Configuration
   input  wire rstx_pkg::rstx_byte_t transmitted_trace_id,
   // Line output
   output rstx_pkg::rstx_byte_t      line_data,
   output logic                      line_fs
);
   import rstx_pkg::*;

   // Counters and the registered line byte.
   logic [11:0] pos_reg, pos_next;
   logic [8:0]  col_reg, col_next;
   logic [3:0]  row_reg, row_next;
   logic [6:0]  scr_reg, scr_next;
   rstx_byte_t  bip_reg, bip_next;
   rstx_byte_t  par_reg, par_next;
   rstx_byte_t  out_reg, out_next;
   logic        fs_reg, fs_next;
   logic        lfs_reg, lfs_next;

   // Decoded slot flags and the byte being built. The flags are plain decodes of the
   // current position and carry no state of their own.
   logic        frame_end;
   logic        col_last;
   logic        slot_clear;
   logic        slot_faw1;
   logic        slot_faw2;
   logic        slot_trace;
   logic        slot_parity;
   logic        slot_seed;
   logic        scr_step;
   rstx_kind_t  kind;
   rstx_byte_t  raw;
   rstx_byte_t  mask;
   logic [6:0]  s;

   // Slot decode from the row and column counters. Only the first overhead row is sent
   // in clear; the second and third rows are scrambled like payload.
   assign frame_end   = (pos_reg == 12'(FRAME_BYTES - 1));
   assign col_last    = (col_reg == 9'(`RSTX_COLS - 1));
   assign slot_clear  = (row_reg == 4'h0) && (col_reg < 9'(`RSTX_SOH_COLS)); // R19
   assign slot_faw1   = slot_clear && (col_reg < 9'h003); // R12
   assign slot_faw2   = slot_clear && (col_reg >= 9'h003) && (col_reg < 9'h006); // R12
   assign slot_trace  = slot_clear && (col_reg == 9'(`RSTX_COL_TRACE - 1)); // R8
   assign slot_parity = (row_reg == 4'h1) && (col_reg == 9'(`RSTX_COL_PARITY - 1)); // R11
   assign slot_seed   = (row_reg == 4'h0) && (col_reg == 9'(`RSTX_SOH_COLS)); // R15

   // Byte position counter over the frame; wraps every frame period. The position count
   // has the last word on the wrap, so a row or column slip cannot outlive one frame.
   always_comb begin
      pos_next = frame_end ? 12'h000 : pos_reg + 12'h001; // R1
      col_next = col_last ? 9'h000 : col_reg + 9'h001;
      row_next = row_reg;
      if (col_last) begin
         row_next = (row_reg == 4'(`RSTX_ROWS - 1)) ? 4'h0 : row_reg + 4'h1;
      end
      if (frame_end) begin
         col_next = 9'h000;
         row_next = 4'h0;
      end
      fs_next  = (pos_next == 12'h000); // R1
      lfs_next = (pos_next == 12'h001); // R1
   end

   // Classify the slot and pick the unscrambled byte. Payload slots pass the source byte
   // through untouched, whatever the channel enables say.
   always_comb begin
      kind = RSTX_SCR;
      raw  = link.ai_data; // R2 R3 R4 R5 R6
      if (slot_faw1) begin
         raw  = `RSTX_FAW1; // R12
         kind = RSTX_FAW;
      end else if (slot_faw2) begin
         raw  = `RSTX_FAW2; // R12
         kind = RSTX_FAW;
      end else if (slot_trace) begin
         raw  = transmitted_trace_id; // R7 R8
         kind = RSTX_UNSCR;
      end else if (slot_clear) begin
         kind = RSTX_UNSCR; // R19
      end else if (slot_parity) begin
         raw  = par_reg; // R11
         kind = RSTX_PAR;
      end
   end

   // The parity byte is scrambled too; only the clear overhead holds the scrambler.
   assign scr_step = (kind == RSTX_SCR) || (kind == RSTX_PAR); // R13

   // Scrambler stepped eight bits per byte, MSB first, as a serial one would be.
   // It holds still through the clear overhead bytes and is reseeded every frame, so
   // the line pattern never depends on anything before the current frame.
   always_comb begin
      s    = slot_seed ? `RSTX_SCR_SEED : scr_reg; // R15
      mask = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         mask[i] = s[6]; // R16
         s       = {s[5:0], s[6] ^ s[5]}; // R14
      end
      scr_next = scr_reg;
      out_next = raw;
      if (scr_step) begin
         scr_next = s; // R13 R17
         out_next = raw ^ mask;
      end
   end

   // Parity over the scrambled output of the whole frame; no error tracking here.
   // The running sum is handed over on the last byte, so the first frame after reset
   // carries a parity of zero that a far end should not count against the line.
   always_comb begin
      bip_next = bip_reg ^ out_next; // R9 R10 R20
      par_next = par_reg;
      if (frame_end) begin
         par_next = bip_next; // R10
         bip_next = 8'h00;
      end
   end

   // Position group. Both frame markers live here because they decode the next position.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pos_reg <= 12'h000;
         col_reg <= 9'h000;
         row_reg <= 4'h0;
         fs_reg  <= 1'b0;
         lfs_reg <= 1'b0;
      end else begin
         pos_reg <= pos_next;
         col_reg <= col_next;
         row_reg <= row_next;
         fs_reg  <= fs_next;
         lfs_reg <= lfs_next;
      end
   end

   // Scrambler group. Its reset value is never used, since the seed is forced at the
   // first scrambled byte of every frame.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scr_reg <= 7'h00;
      end else begin
         scr_reg <= scr_next;
      end
   end

   // Parity group.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bip_reg <= 8'h00;
         par_reg <= 8'h00;
      end else begin
         bip_reg <= bip_next;
         par_reg <= par_next;
      end
   end

   // Line byte group. The line byte is a flop so the physical side sees clean data.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_reg <= 8'h00;
      end else begin
         out_reg <= out_next;
      end
   end

   // Frame start leads the first framing byte by one cycle so the source can align;
   // the line marker is registered and stands on the cycle that shows that byte.
   assign link.fs   = fs_reg;
   assign line_data = out_reg;
   assign line_fs   = lfs_reg;
endmodule // rstx_section_term

// file: bench/rstx_link_properties.sv
// Assertions on the frame start pulse and the payload bytes that the two ends drive.
`timescale 1ns/1ps
module rstx_link_props #(
   parameter int FRAME_BYTES = 2430
) (
   // System
   input wire logic                 clk,
   input wire logic                 sys_rst,
   // Link
   input wire logic                 fs,
   input wire rstx_pkg::rstx_byte_t ai_data,
   input wire logic                 mgmt_en,
   input wire logic                 ow_en,
   input wire logic                 usr_en
);
   import rstx_pkg::*;
   logic [11:0] cnt_reg;
   logic [11:0] cnt_next;
   logic        seen_reg;
   logic        seen_next;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // The period is only judged once a first pulse has fixed the phase.
   always_comb begin
      cnt_next  = fs ? 12'h000 : cnt_reg + 12'h001;
      seen_next = seen_reg | fs;
   end
   always_ff @(posedge clk) begin
      cnt_reg  <= sys_rst ? 12'h000 : cnt_next;
      seen_reg <= sys_rst ? 1'b0 : seen_next;
   end
   sequence quiet8;
      (!fs) [*8];
   endsequence
   sequence ovh_blank7;
      (ai_data == 8'h00) [*7];
   endsequence
   a_fs_one_cycle: assert property (fs |=> quiet8)
      else $error("frame start pulse too long");
   a_frame_period: assert property (seen_reg && fs |-> cnt_reg == FRAME_BYTES - 1)
      else $error("frame start came early");
   a_fs_not_late: assert property (seen_reg && cnt_reg == FRAME_BYTES - 1 |-> fs)
      else $error("frame start missing");
   a_first_frame: assert property (cnt_reg <= FRAME_BYTES + 1)
      else $error("no frame start after reset");
   a_ovh_blank: assert property (fs |-> ovh_blank7)
      else $error("source byte in framing slot not blank");
   a_rst_fs_low: assert property (disable iff (1'b0) sys_rst |=> !fs)
      else $error("frame start during reset");
   cover property (seen_reg && fs);
endmodule // rstx_link_props

// file: bench/testbench.sv
// Bench joining both link ends; the line output is descrambled and compared.
`timescale 1ns/1ps
`include "rstx_regs.svh"
module testbench;
   import rstx_pkg::*;
   typedef struct packed {
      rstx_byte_t ms, nu, ow, usr, mgmt, trc;
      logic       v;
   } rstx_tb_row_t;
   localparam int FB = `RSTX_FRAME_BYTES;
   localparam rstx_tb_row_t ROWS [3] = '{
      '{8'h00, 8'h55, 8'hA1, 8'hB2, 8'hC3, 8'h4A, 1'b1},
      '{8'hFF, 8'h3C, 8'h11, 8'h22, 8'h33, 8'h96, 1'b0},
      '{8'h5A, 8'hC6, 8'hE7, 8'h18, 8'h81, 8'h00, 1'b1}};
   logic         clk;
   logic         sys_rst;
   logic         line_fs;
   logic         ms_take;
   rstx_byte_t   line_data;
   rstx_byte_t   bip;
   logic [6:0]   scr;
   int           cur;
   int           n_mismatch;
   int           check_count;
   rstx_tb_row_t row_q = ROWS[0];
   rstx_link_if link ();
   rstx_payload_src rstx_payload_src_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
      .ms_data(row_q.ms), .ms_take(ms_take), .mgmt_data(row_q.mgmt), .mgmt_valid(row_q.v),
      .ow_data(row_q.ow), .ow_valid(row_q.v), .usr_data(row_q.usr), .usr_valid(row_q.v),
      .nu_data(row_q.nu));
   rstx_section_term #(.FRAME_BYTES(FB)) rstx_section_term_inst (.clk(clk),
      .sys_rst(sys_rst), .link(link), .transmitted_trace_id(row_q.trc),
      .line_data(line_data), .line_fs(line_fs));
   rstx_link_props #(.FRAME_BYTES(FB)) rstx_link_props_inst (.clk(clk), .sys_rst(sys_rst),
      .fs(link.fs), .ai_data(link.ai_data), .mgmt_en(link.mgmt_en), .ow_en(link.ow_en),
      .usr_en(link.usr_en));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) row_q <= ROWS[cur];
   task automatic chk(input rstx_byte_t got, input rstx_byte_t exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         n_mismatch++;
         $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wait_fs(input int lim);
      for (int i = 0; i < lim && line_fs !== 1'b1; i++) @(negedge clk);
      if (line_fs !== 1'b1) begin
         n_mismatch++;
         $display("ERROR %0t: frame start not seen", $time);
         end_sim();
      end
   endtask
   // Descrambles each byte after the first nine with a model of its own so payload values read back plainly.
   task automatic frame(input bit on);
      int         r;
      int         c;
      int         takes;
      rstx_byte_t acc;
      rstx_byte_t d;
      acc = 8'h00;
      takes = 0;
      for (int s = 0; s < FB; s++) begin
         r = s / 270;
         c = s % 270;
         acc ^= line_data;
         if (ms_take === 1'b1) takes++;
         if (s == 9) scr = `RSTX_SCR_SEED;
         d = line_data;
         for (int b = 7; b >= 0 && s >= 9; b--) begin
            d[b] = line_data[b] ^ scr[6];
            scr = {scr[5:0], scr[6] ^ scr[5]};
         end
         if (on) begin
            if (s == 0) chk({7'h00, line_fs}, 8'h01);
            if (s < 3) chk(line_data, `RSTX_FAW1);
            else if (s < 6) chk(line_data, `RSTX_FAW2);
            else if (s == 6) chk(line_data, row_q.trc);
            else if (s < 9) chk(line_data, row_q.nu);
            else if (s == 270) chk(d, bip);
            else if (c >= 9 || r >= 3) chk(d, row_q.ms);
            else if (row_q.v && r == 1 && c == 3) chk(d, row_q.ow);
            else if (row_q.v && r == 1 && c == 6) chk(d, row_q.usr);
            else if (row_q.v && r == 2 && c % 3 == 0) chk(d, row_q.mgmt);
         end
         @(negedge clk);
      end
      if (on) chk_cnt(takes, `RSTX_PAYLOAD_BYTES);
      bip = acc;
   endtask
   initial begin
      sys_rst = 1'b1;
      cur = 0;
      n_mismatch = 0;
      check_count = 0;
      repeat (10) @(negedge clk);
      chk(line_data, 8'h00);
      @(posedge clk) sys_rst <= 1'b0;
      wait_fs(3000);
      frame(1'b0);
      for (int f = 0; f < 3; f++) begin
         cur = f;
         frame(1'b1);
      end
      // A reset in mid-frame must restart framing at once.
      repeat (500) @(negedge clk);
      @(posedge clk) sys_rst <= 1'b1;
      repeat (3) @(negedge clk);
      chk({7'h00, line_fs}, 8'h00);
      @(posedge clk) sys_rst <= 1'b0;
      wait_fs(4);
      frame(1'b0);
      cur = 0;
      frame(1'b1);
      end_sim();
   end
endmodule // testbench
